// file: hw/scss_top.sv
// System clock source selector with prescaler and digital PLL.
`default_nettype none
module scss_top
  import scss_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [DATA_W-1:0] rd_data_o,
  input wire logic direct_clock_pin_i,
  input wire logic crystal_input_pin_i,
  input wire logic internal_osc_i,
  input wire logic wakeup_clk_i,
  output logic sys_clk_o,
  output logic pll_enable_o,
  output logic pll_locked_o,
  output logic [1:0] oscillator_band_select_o
);
  function automatic logic [K1_W-1:0] high_len(input logic [K1_W-1:0] f);
    logic [K1_W:0] s;
    s = {1'b0, f} + 11'h002;
    return s[K1_W:1];
  endfunction

  function automatic logic [PER_W-1:0] ramp(input logic [PER_W-1:0] cur,
    input logic [PER_W-1:0] tgt, input logic [PER_W-1:0] step);
    logic [PER_W-1:0] r;
    r = tgt;
    if (tgt > cur && (tgt - cur) > step)
    begin
      r = cur + step;
    end
    else if (cur > tgt && (cur - tgt) > step)
    begin
      r = cur - step;
    end
    return r;
  endfunction

  logic [PIN_N-1:0] pin_f;
  scss_src_type src, next_src;
  scss_pll_cfg_type cfg, next_cfg;
  logic [K1_W-1:0] k1, next_k1;
  logic [DATA_W-1:0] next_rd_data;
  scss_pll_state_type state, next_state;

  scss_sync #(.W(PIN_N)) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .pin_i({wakeup_clk_i, internal_osc_i, crystal_input_pin_i,
      direct_clock_pin_i}),
    .pin_o(pin_f)
  );

  // Register port.
  always_comb
  begin
    next_src = src;
    next_cfg = cfg;
    next_k1 = k1;
    next_rd_data = '0;
    if (wr_en_i)
    begin
      unique case (addr_i)
        OFS_SYS_CTRL:
        begin
          if (wr_data_i[POS_SRC +: 2] != SRC_RESERVED)
          begin
            next_src = scss_src_type'(wr_data_i[POS_SRC +: 2]);
          end
        end
        OFS_PLL_CTRL:
        begin
          next_cfg.pll_bypass_flag = wr_data_i[POS_BYPASS];
          next_cfg.oscillator_band_select = wr_data_i[POS_BAND +: 2];
          next_cfg.ref_internal = wr_data_i[POS_REF];
          next_cfg.pll_input_divider_field = wr_data_i[POS_PLL_INPUT_DIVIDER_FIELD +: PLL_INPUT_DIVIDER_FIELD_W];
        end
        OFS_PLL_DIV:
        begin
          next_cfg.pll_multiplier_field = wr_data_i[POS_NMUL +: NMUL_W];
          next_cfg.pll_output_divider_field = wr_data_i[POS_K2 +: K2_W];
        end
        OFS_PRESC: next_k1 = wr_data_i[POS_K1 +: K1_W];
        default: next_k1 = k1;
      endcase
    end
    if (rd_en_i)
    begin
      unique case (addr_i)
        OFS_SYS_CTRL: next_rd_data = {14'h0, src};
        OFS_PLL_CTRL: next_rd_data = {8'h0, cfg.pll_input_divider_field,
          cfg.ref_internal, cfg.oscillator_band_select,
          cfg.pll_bypass_flag};
        OFS_PLL_DIV: next_rd_data = {1'b0, cfg.pll_output_divider_field,
          1'b0, cfg.pll_multiplier_field};
        OFS_PRESC: next_rd_data = {6'h0, k1};
        OFS_STATUS: next_rd_data = {12'h0, pll_locked_o, sys_clk_o, src};
        default: next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      src <= RST_SRC;
      cfg <= RST_PLL_CFG;
      k1 <= RST_K1;
      rd_data_o <= '0;
    end
    else if (ce_i)
    begin
      src <= next_src;
      cfg <= next_cfg;
      k1 <= next_k1;
      rd_data_o <= next_rd_data;
    end
  end

  assign oscillator_band_select_o = cfg.oscillator_band_select;

  // Reference selection, prescaler and PLL datapath.
  logic osc_ref, osc_prev, osc_rise, pll_en, ref_event, vco_tick;
  logic presc_out, pll_out, next_sys_clk;
  logic [K1_W-1:0] presc_cnt, next_presc_cnt;
  logic [PLL_INPUT_DIVIDER_FIELD_W-1:0] p_cnt, next_p_cnt;
  logic [PER_W-1:0] per_cnt, next_per_cnt, c_used, next_c_used;
  logic [PER_W-1:0] ramp_step, acc, next_acc;
  logic [PER_W:0] acc_sum, acc_diff;
  logic [7:0] n_val;
  logic [K2_W-1:0] k2_cnt, next_k2_cnt;
  logic vco_tick_q;

  always_comb
  begin
    osc_ref = cfg.ref_internal ? pin_f[PIN_INTOSC] :
      pin_f[PIN_CRYSTAL];
    osc_rise = osc_ref & ~osc_prev;
    pll_en = (src == SRC_OSC) && !cfg.pll_bypass_flag;
    // Prescaler counts oscillator periods up to the field value.
    next_presc_cnt = presc_cnt;
    if (osc_rise)
    begin
      next_presc_cnt = (presc_cnt >= k1) ? '0 : presc_cnt + 10'h001;
    end
    presc_out = (k1 == '0) ? osc_ref :
      (presc_cnt < high_len(k1));
    // Input divider and reference period measurement.
    next_p_cnt = p_cnt;
    ref_event = 1'b0;
    if (osc_rise)
    begin
      if (p_cnt >= cfg.pll_input_divider_field)
      begin
        next_p_cnt = '0;
        ref_event = 1'b1;
      end
      else
      begin
        next_p_cnt = p_cnt + 4'h1;
      end
    end
    next_per_cnt = ref_event ? 16'h0001 :
      ((per_cnt == 16'hffff) ? per_cnt : per_cnt + 16'h0001);
    ramp_step = (c_used >> RAMP_SHIFT) == '0 ? 16'h0001 : c_used >> RAMP_SHIFT;
    // Oscillator: N ticks per measured divided-reference period.
    n_val = {1'b0, cfg.pll_multiplier_field} + 8'h01;
    acc_sum = {1'b0, acc} + {9'h000, n_val};
    acc_diff = acc_sum - {1'b0, c_used};
    vco_tick = (c_used != '0) && (acc_sum >= {1'b0, c_used});
    next_acc = (c_used == '0) ? '0 : !vco_tick ? acc_sum[PER_W-1:0] :
      (acc_diff >= {1'b0, c_used}) ? '0 : acc_diff[PER_W-1:0];
    next_k2_cnt = k2_cnt;
    if (vco_tick)
    begin
      next_k2_cnt = (k2_cnt >= cfg.pll_output_divider_field) ? '0 :
        k2_cnt + 7'h01;
    end
    pll_out = (cfg.pll_output_divider_field == '0) ? vco_tick_q :
      ({3'h0, k2_cnt} < high_len({3'h0, cfg.pll_output_divider_field}));
    if (!pll_en)
    begin
      next_p_cnt = '0;
      next_per_cnt = '0;
      next_acc = '0;
      next_k2_cnt = '0;
    end
    // Output selection.
    unique case (src)
      SRC_DIRECT: next_sys_clk = pin_f[PIN_DIRECT];
      SRC_OSC: next_sys_clk = cfg.pll_bypass_flag ? presc_out :
        pll_out;
      SRC_WAKEUP: next_sys_clk = pin_f[PIN_WAKEUP];
      default: next_sys_clk = sys_clk_o;
    endcase
  end

  // PLL acquisition: the period estimate ramps toward the measurement.
  always_comb
  begin
    next_state = state;
    next_c_used = c_used;
    if (!pll_en)
    begin
      next_state = PLL_OFF;
      next_c_used = '0;
    end
    else if (ref_event)
    begin
      unique case (state)
        PLL_OFF: next_state = PLL_ACQ;
        PLL_ACQ:
        begin
          next_c_used = (c_used == '0) ? per_cnt :
            ramp(c_used, per_cnt, ramp_step);
          if (next_c_used == per_cnt)
          begin
            next_state = PLL_LOCK;
          end
        end
        PLL_LOCK:
        begin
          next_c_used = ramp(c_used, per_cnt, ramp_step);
          if (next_c_used != per_cnt)
          begin
            next_state = PLL_ACQ;
          end
        end
        default: next_state = PLL_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      osc_prev <= 1'b0;
      presc_cnt <= '0;
      p_cnt <= '0;
      per_cnt <= '0;
      c_used <= '0;
      acc <= '0;
      k2_cnt <= '0;
      vco_tick_q <= 1'b0;
      state <= PLL_OFF;
      sys_clk_o <= 1'b0;
      pll_enable_o <= 1'b0;
    end
    else if (ce_i)
    begin
      osc_prev <= osc_ref;
      presc_cnt <= next_presc_cnt;
      p_cnt <= next_p_cnt;
      per_cnt <= next_per_cnt;
      c_used <= next_c_used;
      acc <= next_acc;
      k2_cnt <= next_k2_cnt;
      vco_tick_q <= vco_tick;
      state <= next_state;
      sys_clk_o <= next_sys_clk;
      pll_enable_o <= pll_en;
    end
  end

  assign pll_locked_o = (state == PLL_LOCK);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  chk_reserved_src_kept: assert property (ce_i && wr_en_i &&
    addr_i == OFS_SYS_CTRL && wr_data_i[1:0] == SRC_RESERVED
    |=> src == $past(src))
    else $error("Reserved source code changed the source.");
  chk_direct_follow: assert property (ce_i && src == SRC_DIRECT
    |=> sys_clk_o == $past(pin_f[PIN_DIRECT]))
    else $error("Direct drive does not follow the pin.");
  chk_wakeup_follow: assert property (ce_i && src == SRC_WAKEUP
    |=> sys_clk_o == $past(pin_f[PIN_WAKEUP]))
    else $error("Wakeup mode does not follow the wakeup clock.");
  chk_presc_unity: assert property (ce_i && src == SRC_OSC &&
    cfg.pll_bypass_flag && k1 == '0 |=> sys_clk_o == $past(osc_ref))
    else $error("Prescaler divide one does not pass the oscillator.");
  chk_presc_path: assert property (ce_i && src == SRC_OSC &&
    cfg.pll_bypass_flag |=> sys_clk_o == $past(presc_out))
    else $error("Prescaler mode does not use the prescaler output.");
  chk_presc_range: assert property (ce_i && osc_rise
    |=> presc_cnt <= $past(k1))
    else $error("Prescaler count passed its divide value.");
  chk_pll_enable: assert property (ce_i && src == SRC_OSC &&
    !cfg.pll_bypass_flag |=> pll_enable_o && sys_clk_o == $past(pll_out))
    else $error("PLL mode did not enable and use the PLL.");
  chk_ref_select: assert property (ce_i && cfg.ref_internal
    |-> osc_ref == pin_f[PIN_INTOSC])
    else $error("PLL reference is not the on-chip oscillator.");
  chk_ramp_smooth: assert property (ce_i && pll_en && ref_event &&
    c_used != '0 |=> ((c_used >= $past(c_used)) ?
    (c_used - $past(c_used)) : ($past(c_used) - c_used)) <= $past(ramp_step))
    else $error("PLL period estimate jumped abruptly.");
  chk_acc_step: assert property (ce_i && pll_en && c_used != '0 &&
    !vco_tick |=> acc == $past(acc_sum[PER_W-1:0]))
    else $error("Oscillator accumulator did not add the multiplier.");
  chk_k2_range: assert property (ce_i && vco_tick && pll_en
    |=> k2_cnt <= $past(cfg.pll_output_divider_field))
    else $error("Output divider count passed its divide value.");
  cov_direct: cover property (src == SRC_DIRECT ##1 sys_clk_o);
  cov_locked: cover property (state == PLL_ACQ ##1 state == PLL_LOCK);
  cov_presc: cover property (src == SRC_OSC && cfg.pll_bypass_flag &&
    k1 == 10'h3ff && osc_rise);
  cov_wakeup: cover property (src == SRC_WAKEUP ##1 sys_clk_o);
endmodule // scss_top
`default_nettype wire

// file: shared/scss_pkg.sv
// Shared constants and types of the system clock source selector.
`default_nettype none
package scss_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PLL_INPUT_DIVIDER_FIELD_W = 4;
  localparam int unsigned NMUL_W = 7;
  localparam int unsigned K2_W = 7;
  localparam int unsigned K1_W = 10;
  localparam int unsigned PER_W = 16;
  localparam int unsigned PIN_N = 4;
  // Register offsets on the plain register port.
  localparam logic [2:0] OFS_SYS_CTRL = 3'h0;
  localparam logic [2:0] OFS_PLL_CTRL = 3'h1;
  localparam logic [2:0] OFS_PLL_DIV = 3'h2;
  localparam logic [2:0] OFS_PRESC = 3'h3;
  localparam logic [2:0] OFS_STATUS = 3'h4;
  // Field positions.
  localparam int unsigned POS_SRC = 0;
  localparam int unsigned POS_BYPASS = 0;
  localparam int unsigned POS_BAND = 1;
  localparam int unsigned POS_REF = 3;
  localparam int unsigned POS_PLL_INPUT_DIVIDER_FIELD = 4;
  localparam int unsigned POS_NMUL = 0;
  localparam int unsigned POS_K2 = 8;
  localparam int unsigned POS_K1 = 0;
  // Pin vector positions after synchronisation.
  localparam int unsigned PIN_DIRECT = 0;
  localparam int unsigned PIN_CRYSTAL = 1;
  localparam int unsigned PIN_INTOSC = 2;
  localparam int unsigned PIN_WAKEUP = 3;
  // Divider ramp: the period estimate moves by at most one eighth per step, or by 1 while the estimate is 1 to 7; from 0 it loads the measurement.
  localparam int unsigned RAMP_SHIFT = 3;
  typedef enum logic [1:0] {
    SRC_WAKEUP = 2'h0,
    SRC_RESERVED = 2'h1,
    SRC_OSC = 2'h2,
    SRC_DIRECT = 2'h3
  } scss_src_type;
  typedef enum logic [2:0] {
    PLL_OFF = 3'h1,
    PLL_ACQ = 3'h2,
    PLL_LOCK = 3'h4
  } scss_pll_state_type;
  typedef struct packed {
    logic pll_bypass_flag;
    logic [1:0] oscillator_band_select;
    logic ref_internal;
    logic [PLL_INPUT_DIVIDER_FIELD_W-1:0] pll_input_divider_field;
    logic [NMUL_W-1:0] pll_multiplier_field;
    logic [K2_W-1:0] pll_output_divider_field;
  } scss_pll_cfg_type;
  // Values after reset.
  localparam scss_src_type RST_SRC = SRC_WAKEUP;
  localparam scss_pll_cfg_type RST_PLL_CFG = '{
    pll_bypass_flag: 1'b1,
    oscillator_band_select: 2'h0,
    ref_internal: 1'b0,
    pll_input_divider_field: 4'h0,
    pll_multiplier_field: 7'h0,
    pll_output_divider_field: 7'h0
  };
  localparam logic [K1_W-1:0] RST_K1 = 10'h000;
endpackage
`default_nettype wire

// file: hw/scss_sync.sv
// Three-stage pin synchroniser with agreement filter.
`default_nettype none
module scss_sync
  import scss_pkg::*;
#(
  parameter int unsigned W = 4
)
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  logic [W-1:0] filt;
  logic [W-1:0] next_filt;

  // A bit changes once the second and third stages agree.
  always_comb
  begin
    next_filt = (~(ff2 ^ ff3) & ff3) | ((ff2 ^ ff3) & filt);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
      filt <= '0;
    end
    else if (ce_i)
    begin
      ff1 <= pin_i;
      ff2 <= ff1;
      ff3 <= ff2;
      filt <= next_filt;
    end
  end

  assign pin_o = filt;
endmodule // scss_sync
`default_nettype wire

// file: tb/scss_top_tb_top.sv
// Self-checking testbench of the system clock source selector.
`default_nettype none
`define CHK(a, b) \
  begin \
    samples_checked = samples_checked + 1; \
    if ((a) !== (b)) \
    begin \
      bad_count = bad_count + 1; \
      $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); \
    end \
  end
module scss_top_tb_top
  import scss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] r;
    logic [1:0] band;
  } scss_row_type;
  // Register writes, the read-back they give and the band output after.
  localparam scss_row_type ROWS [12] = '{
    '{3'h0, 16'h0002, 16'h0002, 2'h0},
    '{3'h1, 16'h0001, 16'h0001, 2'h0},
    '{3'h1, 16'h0003, 16'h0003, 2'h1},
    '{3'h1, 16'h0005, 16'h0005, 2'h2},
    '{3'h1, 16'h00ff, 16'h00ff, 2'h3},
    '{3'h2, 16'h7f7f, 16'h7f7f, 2'h3},
    '{3'h3, 16'h03ff, 16'h03ff, 2'h3},
    '{3'h5, 16'hffff, 16'h0000, 2'h3},
    '{3'h7, 16'hffff, 16'h0000, 2'h3},
    '{3'h0, 16'h0003, 16'h0003, 2'h3},
    '{3'h0, 16'h0001, 16'h0003, 2'h3},
    '{3'h0, 16'h0000, 16'h0000, 2'h3}
  };
  localparam logic [DATA_W-1:0] RST_RD [5] = '{16'h0000, 16'h0001,
    16'h0000, 16'h0000, 16'h0000};
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wr_data_i = '0;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [DATA_W-1:0] rd_data_o;
  logic direct_clock_pin_i = 1'b0;
  logic crystal_input_pin_i = 1'b0;
  logic internal_osc_i = 1'b0;
  logic wakeup_clk_i = 1'b0;
  logic sys_clk_o;
  logic pll_enable_o;
  logic pll_locked_o;
  logic [1:0] oscillator_band_select_o;
  logic [7:0] cyc = 8'h00;
  logic [DATA_W-1:0] d;
  logic hang = 1'b0;
  int bad_count = 0;
  int samples_checked = 0;
  int cnt;
  int hi_n;
  int p;
  scss_top uut (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o),
    .direct_clock_pin_i(direct_clock_pin_i),
    .crystal_input_pin_i(crystal_input_pin_i),
    .internal_osc_i(internal_osc_i),
    .wakeup_clk_i(wakeup_clk_i),
    .sys_clk_o(sys_clk_o),
    .pll_enable_o(pll_enable_o),
    .pll_locked_o(pll_locked_o),
    .oscillator_band_select_o(oscillator_band_select_o)
  );
  initial
  begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Source pins run at periods of 8, 16, 32 and 64 system cycles.
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 8'h01;
    direct_clock_pin_i <= cyc[2];
    crystal_input_pin_i <= cyc[3];
    internal_osc_i <= cyc[4];
    wakeup_clk_i <= cyc[5];
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= w;
    wr_en_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_en_i <= 1'b0;
    @(negedge clk_sys_i);
    d = rd_data_o;
  endtask
  // Counts rising edges and high cycles of the system clock in a window.
  task automatic freq(input int n, input int exp);
    logic prev;
    cnt = 0;
    hi_n = 0;
    repeat (400) @(negedge clk_sys_i);
    prev = sys_clk_o;
    repeat (n)
    begin
      @(negedge clk_sys_i);
      if (sys_clk_o === 1'b1 && prev !== 1'b1)
        cnt = cnt + 1;
      if (sys_clk_o === 1'b1)
        hi_n = hi_n + 1;
      prev = sys_clk_o;
    end
    `CHK(cnt >= exp - 1 && cnt <= exp + 1, 1'b1)
  endtask
  // Returns the cycles until the next rising edge of the system clock.
  task automatic rise(output int k);
    logic prev;
    k = 0;
    prev = 1'b1;
    while (!(sys_clk_o === 1'b1 && prev === 1'b0) && k < 40000)
    begin
      prev = sys_clk_o;
      @(negedge clk_sys_i);
      k = k + 1;
    end
    if (k >= 40000)
    begin
      bad_count = bad_count + 1;
      hang = 1'b1;
    end
  endtask
  task automatic wait_lock();
    int i;
    repeat (150) @(negedge clk_sys_i);
    for (i = 0; i < 4000 && pll_locked_o !== 1'b1; i++)
      @(negedge clk_sys_i);
    if (pll_locked_o !== 1'b1)
    begin
      bad_count = bad_count + 1;
      hang = 1'b1;
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic run_all();
    int i;
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (i = 0; i < 12; i++)
    begin
      wr(ROWS[i].a, ROWS[i].w);
      rd(ROWS[i].a);
      `CHK(d, ROWS[i].r)
      `CHK(oscillator_band_select_o, ROWS[i].band)
    end
    wr(OFS_SYS_CTRL, 16'h0003);
    freq(160, 20);
    `CHK(hi_n >= 78 && hi_n <= 82, 1'b1)
    rd(OFS_STATUS);
    `CHK(d & 16'hfffb, 16'h0003)
    wr(OFS_SYS_CTRL, 16'h0001);
    freq(160, 20);
    wr(OFS_PLL_CTRL, 16'h0001);
    wr(OFS_PRESC, 16'h0000);
    wr(OFS_SYS_CTRL, 16'h0002);
    freq(320, 20);
    `CHK(hi_n >= 158 && hi_n <= 162, 1'b1)
    wr(OFS_PRESC, 16'h0003);
    repeat (3) rise(p);
    `CHK(p, 64)
    wr(OFS_PLL_CTRL, 16'h0009);
    wr(OFS_PRESC, 16'h0000);
    freq(640, 20);
    wr(OFS_PLL_CTRL, 16'h0001);
    wr(OFS_PRESC, 16'h03ff);
    repeat (3) rise(p);
    `CHK(p, 16384)
    wr(OFS_SYS_CTRL, 16'h0000);
    freq(640, 10);
    wr(OFS_PLL_DIV, 16'h0103);
    wr(OFS_PLL_CTRL, 16'h0000);
    wr(OFS_SYS_CTRL, 16'h0002);
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK(pll_enable_o, 1'b1)
    `CHK(pll_locked_o, 1'b0)
    wait_lock();
    freq(160, 20);
    rd(OFS_STATUS);
    `CHK(d & 16'hfffb, 16'h000a)
    wr(OFS_PLL_CTRL, 16'h0008);
    wait_lock();
    freq(320, 20);
    wr(OFS_PLL_CTRL, 16'h0018);
    wait_lock();
    freq(640, 20);
    wr(OFS_PLL_DIV, 16'h0003);
    freq(320, 20);
    `CHK(hi_n >= 19 && hi_n <= 21, 1'b1)
    wr(OFS_PLL_CTRL, 16'h0007);
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK(pll_enable_o, 1'b0)
    wr(OFS_PLL_CTRL, 16'h0006);
    repeat (40) @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK({sys_clk_o, pll_enable_o, pll_locked_o}, 3'h0)
    `CHK(oscillator_band_select_o, 2'h0)
    @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (i = 0; i < 5; i++)
    begin
      rd(i[2:0]);
      `CHK(d & ((i == 4) ? 16'hfffb : 16'hffff), RST_RD[i])
    end
    // With the clock enable low, writes are ignored and the output holds.
    wr(OFS_SYS_CTRL, 16'h0003);
    ce_i <= 1'b0;
    wr(OFS_SYS_CTRL, 16'h0000);
    p = sys_clk_o;
    cnt = 0;
    repeat (16)
    begin
      @(negedge clk_sys_i);
      if (sys_clk_o !== p[0])
        cnt = cnt + 1;
    end
    `CHK(cnt, 0)
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    rd(OFS_SYS_CTRL);
    `CHK(d, 16'h0003)
    freq(160, 20);
  endtask
  initial
  begin
    fork
      run_all();
      wait (hang === 1'b1);
    join_any
    end_sim();
  end
endmodule // scss_top_tb_top
`default_nettype wire
